// *** hw/port_cd_pin_function_mux.sv ***
// Purpose: pin function mux for ports C and D (GPIO or serial channel)
// Assumes: serial engines sit outside; they drive and read plain levels
// Notes:   arrays indexed 0 = port D / channel 0, 1 = port C / channel 1
`timescale 1ns/1ns

// Summary of operation
// - each GPIO pin set input or output
// - each pin usable alone as interrupt source
// - output pins selectable open-drain or open-source
// - C shares channel 1, D channel 0
// - MISO input as master, output as slave
// - MOSI output as master, input as slave
// - SCK driven as master, received as slave
// - I2C clock and data both bidirectional
// - UART transmit data out on bit 0
// - UART receive data in on bit 1
// - RTS and DTR driven as active-low outputs
// - CTS, DSR, DCD, RI routed as inputs
// - direction settings reset to all ones
module port_cd_pin_function_mux
  import port_cd_pkg::*;
(
  input  wire logic                 clock,         // system clock, 50 MHz
  input  wire logic                 rst,           // async reset, active high
  input  wire logic [1:0]           cfg_wr,        // per-port setting write strobe
  input  wire cfg_t                 cfg_sel,       // which setting is written
  input  wire logic [7:0]           cfg_wdata,     // setting value
  input  wire mode_t [1:0]          chan_mode,     // serial personality per channel
  input  wire logic [1:0]           spi_master,    // 1 = channel is SPI master
  input  wire logic [1:0]           spi_miso_out,  // MISO value as slave
  input  wire logic [1:0]           spi_mosi_out,  // MOSI value as master
  input  wire logic [1:0]           spi_sck_out,   // SCK value as master
  input  wire logic [1:0]           i2c_scl_low,   // pull SCL low
  input  wire logic [1:0]           i2c_sda_low,   // pull SDA low
  input  wire logic [1:0]           uart_txd,      // transmit data
  input  wire logic [1:0]           uart_rts_n,    // request to send, low active
  input  wire logic [1:0]           uart_dtr_n,    // terminal ready, low active
  input  wire logic [1:0][7:0]      pin_in,        // pin levels from pads
  input  wire logic                 test_pin,      // factory test pad
  output logic      [1:0][7:0]      pin_out,       // pad output value
  output logic      [1:0][7:0]      pin_oe_n,      // pad enable, low = drive
  output logic      [1:0][7:0]      gpio_in,       // synchronised pin levels
  output logic      [1:0][7:0]      gpio_event,    // pin change pulse
  output logic      [1:0][7:0]      direction_q,   // current direction setting
  output logic      [1:0]           spi_miso_in,   // MISO to channel
  output logic      [1:0]           spi_mosi_in,   // MOSI to channel
  output logic      [1:0]           spi_sck_in,    // SCK to channel
  output logic      [1:0]           spi_ss_n,      // slave select, low active
  output logic      [1:0]           i2c_scl_in,    // SCL level to channel
  output logic      [1:0]           i2c_sda_in,    // SDA level to channel
  output logic      [1:0]           uart_rxd,      // receive data
  output logic      [1:0]           uart_cts_n,    // clear to send
  output logic      [1:0]           uart_dsr_n,    // data set ready
  output logic      [1:0]           uart_dcd_n,    // carrier detect
  output logic      [1:0]           uart_ri_n,     // ring indicator
  output logic                      test_mode      // factory test level
);

  // software settings, one byte per port
  logic [1:0][7:0] data_reg;
  logic [1:0][7:0] port_c_direction_reg;  // both ports, index 1 is C
  logic [1:0][7:0] odrain_reg;
  logic [1:0][7:0] osource_reg;
  logic [1:0][7:0] alt_reg;
  logic [1:0][7:0] inten_reg;

  // pin side state
  logic [16:0]     sync_q;
  logic [1:0][7:0] sync_pin;
  logic [1:0][7:0] prev_reg;
  logic [1:0][7:0] event_reg;
  logic [1:0][7:0] pin_out_reg;
  logic [1:0][7:0] pin_oe_n_reg;
  logic [1:0][7:0] drive_next;
  logic [1:0][7:0] value_next;
  logic [1:0][7:0] ser_pin;
  logic [1:0][10:0] route_next;
  logic [1:0][10:0] route_reg;

  // per-pin drive from the serial channel: {drive, value}
  function automatic logic [15:0] serial_pins(
    input mode_t m,
    input logic  master,
    input logic  miso,
    input logic  mosi,
    input logic  sck,
    input logic  scl_low,
    input logic  sda_low,
    input logic  txd,
    input logic  rts_n,
    input logic  dtr_n
  );
    logic [7:0] drv;
    logic [7:0] val;
    drv = 8'h00;
    val = 8'h00;
    unique case (m)
      MODE_SPI: begin
        drv[BIT_MISO] = ~master;
        val[BIT_MISO] = miso;
        drv[BIT_MOSI] = master;
        val[BIT_MOSI] = mosi;
        drv[BIT_SCK]  = master;
        val[BIT_SCK]  = sck;
      end
      MODE_I2C: begin
        drv[BIT_SCL] = scl_low;
        drv[BIT_SDA] = sda_low;
      end
      MODE_UART: begin
        drv[BIT_TXD] = 1'b1;
        val[BIT_TXD] = txd;
        drv[BIT_RTS] = 1'b1;
        val[BIT_RTS] = rts_n;
        drv[BIT_DTR] = 1'b1;
        val[BIT_DTR] = dtr_n;
      end
      default: begin
        drv = 8'h00;
      end
    endcase
    return {drv, val};
  endfunction : serial_pins

  sync_bank #(
    .WIDTH (17)
  ) u_sync (
    .clock   (clock),
    .rst     (rst),
    .d_async ({test_pin, pin_in[1], pin_in[0]}),
    .q       (sync_q)
  );

  assign sync_pin[0] = sync_q[7:0];
  assign sync_pin[1] = sync_q[15:8];
  assign test_mode   = sync_q[16];

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      data_reg             <= {NUM_PORTS{DATA_RESET}};
      port_c_direction_reg <= {NUM_PORTS{DIR_RESET}};
      odrain_reg           <= {NUM_PORTS{ODR_RESET}};
      osource_reg          <= {NUM_PORTS{OSR_RESET}};
      alt_reg              <= {NUM_PORTS{ALT_RESET}};
      inten_reg            <= {NUM_PORTS{INTEN_RESET}};
    end else begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (cfg_wr[p]) begin
          unique case (cfg_sel)
            CFG_DATA:    data_reg[p]             <= cfg_wdata;
            CFG_DIR:     port_c_direction_reg[p] <= cfg_wdata;
            CFG_ODRAIN:  odrain_reg[p]           <= cfg_wdata;
            CFG_OSOURCE: osource_reg[p]          <= cfg_wdata;
            CFG_ALT:     alt_reg[p]              <= cfg_wdata;
            CFG_INTEN:   inten_reg[p]            <= cfg_wdata;
            default:     ;
          endcase
        end
      end
    end
  end

  for (genvar gp = 0; gp < NUM_PORTS; gp++) begin : g_port
    logic [15:0] ser;
    logic [7:0]  gpio_drive;
    logic        is_spi;
    logic        is_i2c;
    logic        is_uart;

    // each port bound to its own channel
    assign ser = serial_pins(chan_mode[gp], spi_master[gp], spi_miso_out[gp],
                             spi_mosi_out[gp], spi_sck_out[gp], i2c_scl_low[gp],
                             i2c_sda_low[gp], uart_txd[gp], uart_rts_n[gp],
                             uart_dtr_n[gp]);

    // open-drain drives low only, open-source high only
    assign gpio_drive = ~port_c_direction_reg[gp]
                      & ~(odrain_reg[gp] & data_reg[gp])
                      & ~(osource_reg[gp] & ~data_reg[gp]);

    assign drive_next[gp] = (alt_reg[gp] & ser[15:8]) | (~alt_reg[gp] & gpio_drive);
    assign value_next[gp] = (alt_reg[gp] & ser[7:0]) | (~alt_reg[gp] & data_reg[gp]);

    // serial inputs idle high when pin not given to the channel
    assign ser_pin[gp] = (alt_reg[gp] & sync_pin[gp]) | (~alt_reg[gp] & IDLE_IN);
    assign is_spi      = (chan_mode[gp] == MODE_SPI);
    assign is_i2c      = (chan_mode[gp] == MODE_I2C);
    assign is_uart     = (chan_mode[gp] == MODE_UART);

    assign route_next[gp] = {
      ~is_uart | ser_pin[gp][BIT_RI],
      ~is_uart | ser_pin[gp][BIT_DCD],
      ~is_uart | ser_pin[gp][BIT_DSR],
      ~is_uart | ser_pin[gp][BIT_CTS],
      ~is_uart | ser_pin[gp][BIT_RXD],
      ~is_i2c  | ser_pin[gp][BIT_SDA],
      ~is_i2c  | ser_pin[gp][BIT_SCL],
      ~is_spi  | ser_pin[gp][BIT_SS],
      ~is_spi  | ser_pin[gp][BIT_SCK],
      ~is_spi  | ser_pin[gp][BIT_MOSI],
      ~is_spi  | ser_pin[gp][BIT_MISO]
    };

    assign spi_miso_in[gp] = route_reg[gp][0];
    assign spi_mosi_in[gp] = route_reg[gp][1];
    assign spi_sck_in[gp]  = route_reg[gp][2];
    assign spi_ss_n[gp]    = route_reg[gp][3];  // low selects us
    assign i2c_scl_in[gp]  = route_reg[gp][4];
    assign i2c_sda_in[gp]  = route_reg[gp][5];
    assign uart_rxd[gp]    = route_reg[gp][6];
    assign uart_cts_n[gp]  = route_reg[gp][7];
    assign uart_dsr_n[gp]  = route_reg[gp][8];
    assign uart_dcd_n[gp]  = route_reg[gp][9];
    assign uart_ri_n[gp]   = route_reg[gp][10];
  end

  // pad drive, input routing, change events
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pin_out_reg  <= '0;
      pin_oe_n_reg <= '1;
      route_reg    <= '1;
      prev_reg     <= '0;
      event_reg    <= '0;
    end else begin
      pin_out_reg  <= value_next;
      pin_oe_n_reg <= ~drive_next;
      route_reg    <= route_next;
      prev_reg     <= sync_pin;
      event_reg    <= inten_reg & (sync_pin ^ prev_reg);
    end
  end

  assign pin_out     = pin_out_reg;
  assign pin_oe_n    = pin_oe_n_reg;
  assign gpio_in     = sync_pin;
  assign gpio_event  = event_reg;
  assign direction_q = port_c_direction_reg;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  for (genvar ap = 0; ap < NUM_PORTS; ap++) begin : g_chk
    chk_gpio_input_hiz: assert property (
      ($past(~alt_reg[ap] & port_c_direction_reg[ap]) & ~pin_oe_n[ap]) == 8'h00)
      else $error("gpio input pin driven");
    chk_open_drive_kind: assert property (
      (($past(~alt_reg[ap] & ~port_c_direction_reg[ap] & odrain_reg[ap] & data_reg[ap])
       | $past(~alt_reg[ap] & ~port_c_direction_reg[ap] & osource_reg[ap] & ~data_reg[ap]))
       & ~pin_oe_n[ap]) == 8'h00)
      else $error("open drain or source drove wrong level");
    chk_gpio_drive_value: assert property (
      ($past(~alt_reg[ap] & ~port_c_direction_reg[ap] & ~odrain_reg[ap] & ~osource_reg[ap])
       & (pin_oe_n[ap] | (pin_out[ap] ^ $past(data_reg[ap])))) == 8'h00)
      else $error("gpio output not driving data");
    chk_miso_role_dir: assert property (
      $past(alt_reg[ap][BIT_MISO] && chan_mode[ap] == MODE_SPI)
      |-> pin_oe_n[ap][BIT_MISO] == $past(spi_master[ap]))
      else $error("miso direction wrong for role");
    chk_mosi_role_dir: assert property (
      $past(alt_reg[ap][BIT_MOSI] && chan_mode[ap] == MODE_SPI)
      |-> pin_oe_n[ap][BIT_MOSI] == !$past(spi_master[ap]))
      else $error("mosi direction wrong for role");
    chk_sck_master_out: assert property (
      $past(alt_reg[ap][BIT_SCK] && chan_mode[ap] == MODE_SPI && spi_master[ap])
      |-> !pin_oe_n[ap][BIT_SCK] && pin_out[ap][BIT_SCK] == $past(spi_sck_out[ap]))
      else $error("sck not driven as master");
    // I2C clock pulled low on request
    chk_i2c_scl_low: assert property (
      $past(alt_reg[ap][BIT_SCL] && chan_mode[ap] == MODE_I2C)
      |-> pin_oe_n[ap][BIT_SCL] == !$past(i2c_scl_low[ap]) && !pin_out[ap][BIT_SCL])
      else $error("i2c clock drive wrong");
    chk_uart_out_pins: assert property (
      $past(alt_reg[ap][BIT_TXD] && alt_reg[ap][BIT_RTS] && alt_reg[ap][BIT_DTR] && chan_mode[ap] == MODE_UART)
      |-> !pin_oe_n[ap][BIT_TXD] && pin_out[ap][BIT_TXD] == $past(uart_txd[ap])
          && !pin_oe_n[ap][BIT_RTS] && pin_out[ap][BIT_RTS] == $past(uart_rts_n[ap])
          && !pin_oe_n[ap][BIT_DTR] && pin_out[ap][BIT_DTR] == $past(uart_dtr_n[ap]))
      else $error("uart output pin wrong");
    chk_uart_rx_route: assert property (
      $past(alt_reg[ap][BIT_RXD] && chan_mode[ap] == MODE_UART)
      |-> uart_rxd[ap] == $past(gpio_in[ap][BIT_RXD]) && pin_oe_n[ap][BIT_RXD])
      else $error("uart receive not routed");
    // clear to send follows the pin
    chk_modem_status: assert property (
      $past(alt_reg[ap][BIT_CTS] && chan_mode[ap] == MODE_UART)
      |-> uart_cts_n[ap] == $past(gpio_in[ap][BIT_CTS]))
      else $error("modem status not routed");
    chk_dir_reset_ones: assert property (
      $fell(rst) |-> direction_q[ap] == DIR_RESET)
      else $error("direction not all ones after reset");
    chk_sync_latency: assert property (
      !$past(rst) && !$past(rst, 2) && !$past(rst, 3) |-> gpio_in[ap] == $past(pin_in[ap], 2))
      else $error("input not synchronised by two flops");
    chk_event_cause: assert property (
      !$past(rst) && !$past(rst, 2)
      |-> gpio_event[ap] == ($past(inten_reg[ap]) & ($past(gpio_in[ap]) ^ $past(gpio_in[ap], 2))))
      else $error("pin event mismatch");

    cov_spi_master: cover property (alt_reg[ap][BIT_SCK] && chan_mode[ap] == MODE_SPI && spi_master[ap]);
    cov_spi_slave_sel: cover property (chan_mode[ap] == MODE_SPI && !spi_master[ap] && !spi_ss_n[ap]);
    cov_uart_active: cover property (alt_reg[ap][BIT_TXD] && chan_mode[ap] == MODE_UART);
    cov_gpio_event: cover property (gpio_event[ap] != 8'h00);
  end

endmodule : port_cd_pin_function_mux

// *** hw/port_cd_pkg.sv ***
// Purpose: shared constants and types for the port C/D pin function mux
// Assumes: two 8-bit ports, one serial channel per port
// Notes:   index 0 of every port array is port D, index 1 is port C
package port_cd_pkg;

  localparam int PORT_WIDTH  = 8;
  localparam int NUM_PORTS   = 2;
  localparam int SYNC_STAGES = 2;
  localparam int PORT_D      = 0;  // carries serial channel 0
  localparam int PORT_C      = 1;  // carries serial channel 1

  // reset values of the software settings
  localparam logic [7:0] DIR_RESET   = 8'hFF;  // all pins input
  localparam logic [7:0] DATA_RESET  = 8'h00;
  localparam logic [7:0] ODR_RESET   = 8'h00;
  localparam logic [7:0] OSR_RESET   = 8'h00;
  localparam logic [7:0] ALT_RESET   = 8'h00;
  localparam logic [7:0] INTEN_RESET = 8'h00;
  localparam logic [7:0] IDLE_IN     = 8'hFF;  // serial inputs idle high

  // pin positions of the serial functions
  localparam int BIT_MISO = 0;
  localparam int BIT_SCL  = 0;
  localparam int BIT_TXD  = 0;
  localparam int BIT_MOSI = 1;
  localparam int BIT_SDA  = 1;
  localparam int BIT_RXD  = 1;
  localparam int BIT_SCK  = 2;
  localparam int BIT_RTS  = 2;
  localparam int BIT_SS   = 3;
  localparam int BIT_CTS  = 3;
  localparam int BIT_DTR  = 4;
  localparam int BIT_DSR  = 5;
  localparam int BIT_DCD  = 6;
  localparam int BIT_RI   = 7;

  // serial channel personality
  typedef enum logic [1:0] {
    MODE_SPI,
    MODE_I2C,
    MODE_UART
  } mode_t;

  // software setting selected by a configuration write
  typedef enum logic [2:0] {
    CFG_DATA,
    CFG_DIR,
    CFG_ODRAIN,
    CFG_OSOURCE,
    CFG_ALT,
    CFG_INTEN
  } cfg_t;

endpackage : port_cd_pkg

// *** hw/sync_bank.sv ***
// Purpose: two-flop synchroniser bank for asynchronous pin levels
// Assumes: inputs are levels, not pulses
// Notes:   only the second stage may be read by other logic
`timescale 1ns/1ns
module sync_bank
  import port_cd_pkg::*;
#(
  parameter int WIDTH = 17
) (
  input  wire logic             clock,    // system clock
  input  wire logic             rst,      // async reset, active high
  input  wire logic [WIDTH-1:0] d_async,  // pin levels
  output logic      [WIDTH-1:0] q         // synchronised levels
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] q_reg;

  // refuse an empty bank
  if (WIDTH < 1) begin : g_bad_width
    $error("sync_bank WIDTH must be at least 1");
  end

  // first stage feeds only the second stage
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      meta_reg <= '0;
      q_reg    <= '0;
    end else begin
      meta_reg <= d_async;
      q_reg    <= meta_reg;
    end
  end

  assign q = q_reg;

endmodule : sync_bank

// *** verification/pad_board.sv ***
// Purpose: board model for the port C and D pads
// Assumes: every port pad has a board pull-up, test pad tied low; device drive wins a clash
// Notes:   the bench picks what the outside devices drive
`timescale 1ns/1ns
module pad_board
  import port_cd_pkg::*;
(
  input  wire logic [1:0][7:0] pin_out,   // device pad value
  input  wire logic [1:0][7:0] pin_oe_n,  // device drives when low
  input  wire logic [1:0][7:0] ext_val,   // outside device value
  input  wire logic [1:0][7:0] ext_en,    // outside device drives
  output logic      [1:0][7:0] pin_in,    // resolved pad level
  output logic                 test_pin   // factory test pad
);
  assign test_pin = 1'b0;

  // device first, then outside device, else pull-up
  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      pin_in[p] = (~pin_oe_n[p] & pin_out[p]) | (pin_oe_n[p] & ext_en[p] & ext_val[p])
                | (pin_oe_n[p] & ~ext_en[p]);
    end
  end
endmodule : pad_board

// *** verification/tb.sv ***
// Purpose: self-checking bench for the port C/D pin function mux
// Assumes: pads resolved by pad_board with pull-ups
// Notes:   inputs change on the falling edge
`timescale 1ns/1ns
module tb
  import port_cd_pkg::*;
();
  logic            clock, rst, test_pin, test_mode;
  logic [1:0]      cfg_wr, spi_master, miso_o, mosi_o, sck_o, scl_lo, sda_lo, txd, rts_n, dtr_n;
  cfg_t            cfg_sel;
  logic [7:0]      cfg_wdata, hits;
  mode_t [1:0]     chan_mode;
  logic [1:0][7:0] ext_val, ext_en, pin_in, pin_out, pin_oe_n, gpio_in, gpio_event, direction_q;
  logic [1:0]      miso_i, mosi_i, sck_i, ss_n, scl_i, sda_i, rxd, cts_n, dsr_n, dcd_n, ri_n;
  int              fail_count, n_tests;

  port_cd_pin_function_mux DUT (
    .clock(clock), .rst(rst), .cfg_wr(cfg_wr), .cfg_sel(cfg_sel), .cfg_wdata(cfg_wdata),
    .chan_mode(chan_mode), .spi_master(spi_master), .spi_miso_out(miso_o), .spi_mosi_out(mosi_o),
    .spi_sck_out(sck_o), .i2c_scl_low(scl_lo), .i2c_sda_low(sda_lo), .uart_txd(txd),
    .uart_rts_n(rts_n), .uart_dtr_n(dtr_n), .pin_in(pin_in), .test_pin(test_pin),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .gpio_in(gpio_in), .gpio_event(gpio_event),
    .direction_q(direction_q), .spi_miso_in(miso_i), .spi_mosi_in(mosi_i), .spi_sck_in(sck_i),
    .spi_ss_n(ss_n), .i2c_scl_in(scl_i), .i2c_sda_in(sda_i), .uart_rxd(rxd), .uart_cts_n(cts_n),
    .uart_dsr_n(dsr_n), .uart_dcd_n(dcd_n), .uart_ri_n(ri_n), .test_mode(test_mode)
  );

  pad_board board (
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_val(ext_val), .ext_en(ext_en),
    .pin_in(pin_in), .test_pin(test_pin)
  );

  // 50 MHz clock
  initial clock = 1'b0;
  always #10 clock = ~clock;

  // compare and count
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one setting write; strobe stays up until settle
  task automatic wr(input int p, input cfg_t s, input logic [7:0] v);
    cfg_wr = 2'b01 << p;
    cfg_sel = s;
    cfg_wdata = v;
    @(negedge clock);
  endtask : wr

  // drop the strobe and let pads and synchronisers land
  task automatic settle();
    cfg_wr = 2'b00;
    repeat (4) @(negedge clock);
  endtask : settle

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : print_verdict

  initial begin
    fail_count = 0;
    n_tests = 0;
    rst = 1'b1;
    cfg_wr = 2'b00;
    cfg_sel = CFG_DATA;
    cfg_wdata = 8'h00;
    chan_mode[0] = MODE_SPI;
    chan_mode[1] = MODE_SPI;
    {spi_master, miso_o, mosi_o, sck_o, scl_lo, sda_lo, txd, rts_n, dtr_n} = '0;
    ext_val = '0;
    ext_en = '0;
    repeat (19) @(negedge clock);
    chk("direction reset", 8'hFF, direction_q[0]);
    chk("direction reset", 8'hFF, direction_q[1]);
    @(negedge clock);
    rst = 1'b0;
    @(negedge clock);
    chk("test mode", 8'h00, {7'h00, test_mode});
    for (int p = 0; p < NUM_PORTS; p++) begin
      wr(p, CFG_DATA, 8'h5A);
      wr(p, CFG_DIR, 8'h0F);
      settle();
      chk("direction", 8'h0F, direction_q[p]);
      chk("gpio enable", 8'h0F, pin_oe_n[p]);
      chk("gpio value", 8'h5A, pin_out[p]);
      chk("gpio level", 8'h5F, gpio_in[p]);
      wr(p, CFG_ODRAIN, 8'hF0);
      wr(p, CFG_OSOURCE, 8'h0F);
      wr(p, CFG_DIR, 8'h00);
      wr(p, CFG_DATA, 8'hA5);
      settle();
      chk("drain source enable", 8'hAA, pin_oe_n[p]);
      chk("drain source level", 8'hAF, gpio_in[p]);
      wr(p, CFG_ODRAIN, 8'h00);
      wr(p, CFG_OSOURCE, 8'h00);
      wr(p, CFG_DIR, 8'hFF);
      wr(p, CFG_INTEN, 8'h01);
      ext_en[p] = 8'h03;
      ext_val[p] = 8'h03;
      settle();
      ext_val[p] = 8'h00;
      hits = 8'h00;
      repeat (8) begin
        @(negedge clock);
        hits = hits + {6'h00, gpio_event[p][1:0]};
      end
      chk("events", 8'h01, hits);
      chk("event level", 8'h00, {6'h00, gpio_in[p][1:0]});
      wr(p, CFG_INTEN, 8'h00);
      wr(p, CFG_ALT, 8'hFF);
      chan_mode[p] = MODE_SPI;
      spi_master[p] = 1'b1;
      mosi_o[p] = 1'b1;
      sck_o[p] = 1'b1;
      ext_en[p] = 8'h09;
      settle();
      chk("master enable", 8'hF9, pin_oe_n[p]);
      chk("master out", 8'h03, {6'h00, pin_out[p][2:1]});
      chk("miso in", 8'h00, {7'h00, miso_i[p]});
      spi_master[p] = 1'b0;
      ext_en[p] = 8'h0E;
      ext_val[p] = 8'h04;
      settle();
      chk("slave enable", 8'hFE, pin_oe_n[p]);
      chk("slave in", 8'h02, {5'h00, mosi_i[p], sck_i[p], ss_n[p]});
      chan_mode[p] = MODE_I2C;
      scl_lo[p] = 1'b1;
      ext_en[p] = 8'h00;
      settle();
      chk("i2c enable", 8'hFE, pin_oe_n[p]);
      chk("i2c in", 8'h01, {6'h00, scl_i[p], sda_i[p]});
      scl_lo[p] = 1'b0;
      sda_lo[p] = 1'b1;
      settle();
      chk("i2c enable", 8'hFD, pin_oe_n[p]);
      chk("i2c in", 8'h02, {6'h00, scl_i[p], sda_i[p]});
      sda_lo[p] = 1'b0;
      wr(p, CFG_DIR, 8'h00);
      wr(p, CFG_DATA, 8'hFF);
      chan_mode[p] = MODE_UART;
      rts_n[p] = 1'b1;
      ext_en[p] = 8'hEA;
      ext_val[p] = 8'hA0;
      settle();
      chk("uart enable", 8'hEA, pin_oe_n[p]);
      chk("uart out", 8'h04, pin_out[p] & 8'h15);
      chk("uart in", 8'h05, {3'h0, rxd[p], cts_n[p], dsr_n[p], dcd_n[p], ri_n[p]});
      chk("select idle", 8'h01, {7'h00, ss_n[p]});
      chk("other port", 8'hFF, pin_oe_n[1-p]);
      txd[p] = 1'b1;
      dtr_n[p] = 1'b1;
      ext_val[p] = 8'hA2;
      settle();
      chk("txd out", 8'h15, pin_out[p] & 8'h15);
      chk("rxd in", 8'h01, {7'h00, rxd[p]});
      // back to plain inputs for the next port
      wr(p, CFG_ALT, 8'h00);
      wr(p, CFG_DIR, 8'hFF);
      chan_mode[p] = MODE_SPI;
      {txd[p], rts_n[p], dtr_n[p], mosi_o[p], sck_o[p]} = 5'b00000;
      ext_en[p] = 8'h00;
      settle();
      chk("restored", 8'hFF, pin_oe_n[p]);
      $display("port %0d tests done", p);
    end
    print_verdict();
  end
endmodule : tb
